// ---- rtl/ubg_baud_gen.sv ----
// Baud rate generator with divisor and mode registers
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ns
// Functional notes
// - High byte holds divisor 15:8, resets zero
// - Narrow mode leaves high byte out of the divisor
// - Writing high byte restarts the counter
// - Divisor is high byte joined with low
// - Async narrow normal speed divides by 64(n+1)
// - Async wide normal speed divides by 16(n+1)
// - Clocked mode always divides by 4(n+1)
// - Writing low byte restarts the counter
// - Wide select one means 16-bit divisor
// - Mode bit one selects clocked mode
module ubg_baud_gen
  import ubg_pkg::*;
#(
  parameter int DIV_WIDTH = 16
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  output logic            baud_tick,
  output logic            sync_mode,
  output logic            wide_mode
);
  // Two byte registers make the divisor; nothing else is served
  if (DIV_WIDTH != 16) begin : g_bad_div
    $error("ubg_baud_gen: DIV_WIDTH must be 16");
  end

  logic [7:0]  divisor_low;          // baud_divisor_low
  logic [7:0]  divisor_high;         // baud_divisor_high
  logic [7:0]  tx_ctrl;              // transmit_status_control
  logic [7:0]  baud_ctrl;            // baud_rate_control
  logic [7:0]  next_divisor_low;     // Next low byte
  logic [7:0]  next_divisor_high;    // Next high byte
  logic [7:0]  next_tx_ctrl;         // Next transmit control
  logic [7:0]  next_baud_ctrl;       // Next baud control
  logic [7:0]  next_rd_data;         // Next read data
  logic        next_baud_tick;       // Next tick output
  logic        wide_sel;             // Wide divisor select
  logic        hs_sel;               // High speed select
  logic        sync_sel;             // Clocked mode select
  logic        restart;              // Counter restart request
  logic [15:0] eff_div;              // Divisor in use
  logic [5:0]  pre_limit;            // Prescaler limit
  logic [15:0] gen_count;            // Main counter value
  logic        gen_wrap;             // Main counter wrap
  logic [5:0]  pre_count;            // Prescaler value
  logic        pre_wrap;             // Prescaler wrap

  // Mode decode from control registers
  assign wide_sel = baud_ctrl[BRC_WIDE_BIT];
  assign sync_sel = tx_ctrl[TXC_SYNC_BIT];
  assign hs_sel   = tx_ctrl[TXC_HSPEED_BIT];
  assign pre_limit = ubg_pre_limit(sync_sel, wide_sel,
                                   hs_sel);

  // Divisor pair, high byte masked in narrow mode
  assign eff_div = wide_sel ? {divisor_high, divisor_low}
                            : {8'h00, divisor_low};

  // Any divisor write restarts both counters
  assign restart = wr_en && ((addr == ADDR_DIV_HIGH) ||
                             (addr == ADDR_DIV_LOW));

  // Main counter: period of divisor plus one cycles
  ubg_counter #(.WIDTH(16)) u_gen (
    .mclk   (mclk),
    .nrst   (nrst),
    .clear  (restart),
    .enable (1'b1),
    .limit  (eff_div),
    .count  (gen_count),
    .wrap   (gen_wrap)
  );

  // Prescaler: divides main wraps by 4, 16 or 64
  ubg_counter #(.WIDTH(6)) u_pre (
    .mclk   (mclk),
    .nrst   (nrst),
    .clear  (restart),
    .enable (gen_wrap),
    .limit  (pre_limit),
    .count  (pre_count),
    .wrap   (pre_wrap)
  );

  // Register writes and read data
  always_comb begin
    next_divisor_low  = divisor_low;
    next_divisor_high = divisor_high;
    next_tx_ctrl      = tx_ctrl;
    next_baud_ctrl    = baud_ctrl;
    next_rd_data      = 8'h00;
    next_baud_tick    = pre_wrap;
    if (wr_en) begin
      case (addr)
        ADDR_DIV_LOW: begin
          next_divisor_low = wr_data;
        end
        ADDR_DIV_HIGH: begin
          next_divisor_high = wr_data;
        end
        ADDR_TX_CTRL: begin
          next_tx_ctrl = (wr_data & TX_CTRL_WMASK) |
                         (TX_CTRL_RST & ~TX_CTRL_WMASK);
        end
        ADDR_BAUD_CTRL: begin
          next_baud_ctrl = (wr_data & BAUD_CTRL_WMASK) |
                           (BAUD_CTRL_RST & ~BAUD_CTRL_WMASK);
        end
        default: begin
          // Unmapped or read-only offsets ignore writes
        end
      endcase
    end
    if (rd_en) begin
      case (addr)
        ADDR_DIV_LOW:   next_rd_data = divisor_low;
        ADDR_DIV_HIGH:  next_rd_data = divisor_high;
        ADDR_TX_CTRL:   next_rd_data = tx_ctrl;
        ADDR_BAUD_CTRL: next_rd_data = baud_ctrl;
        ADDR_COUNT:     next_rd_data = gen_count[7:0];
        default:        next_rd_data = 8'h00;
      endcase
    end
  end

  // Register state and outputs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      divisor_low  <= DIV_LOW_RST;
      divisor_high <= DIV_HIGH_RST;
      tx_ctrl      <= TX_CTRL_RST;
      baud_ctrl    <= BAUD_CTRL_RST;
      rd_data      <= 8'h00;
      baud_tick    <= 1'b0;
    end else begin
      divisor_low  <= next_divisor_low;
      divisor_high <= next_divisor_high;
      tx_ctrl      <= next_tx_ctrl;
      baud_ctrl    <= next_baud_ctrl;
      rd_data      <= next_rd_data;
      baud_tick    <= next_baud_tick;
    end
  end

  assign sync_mode = sync_sel;
  assign wide_mode = wide_sel;

  // Helper: cycles between ticks over a clean period
  logic [GAP_WIDTH-1:0] gap;         // Cycles since last tick
  logic [15:0]          rule_div;    // Divisor as the rules join it
  logic                 clean;       // Period with no disturbance
  logic                 cfg_wr;      // Mode register write

  assign cfg_wr = wr_en && ((addr == ADDR_TX_CTRL) ||
                            (addr == ADDR_BAUD_CTRL));
  // Divisor the rate checks expect: high byte only when wide
  assign rule_div = wide_sel ? {divisor_high, divisor_low}
                             : {8'h00, divisor_low};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gap   <= 24'h000001;
      clean <= 1'b0;
    end else begin
      gap   <= (baud_tick || restart) ? 24'h000001 : gap + 24'h000001;
      clean <= (clean || baud_tick) && !restart && !cfg_wr;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_high_store: assert property (wr_en && addr == ADDR_DIV_HIGH |=>
    divisor_high == $past(wr_data))
    else $error("high byte not stored");
  chk_narrow_mask: assert property (!wide_sel && gen_wrap |->
    gen_count == {8'h00, divisor_low})
    else $error("high byte used in narrow mode");
  chk_high_restart: assert property (
    wr_en && addr == ADDR_DIV_HIGH |=>
    gen_count == 16'h0000 && pre_count == 6'h00 ##1 !baud_tick)
    else $error("high write did not restart");
  chk_pair_join: assert property (wide_sel && gen_wrap |->
    gen_count == {divisor_high, divisor_low})
    else $error("divisor pair wrong");
  // Rate checks skip the first tick after a restart or mode write,
  // since that period is not a whole one
  chk_rate_async8: assert property (baud_tick && clean && !sync_sel &&
    !wide_sel && !hs_sel |-> gap == 24'd64 * (24'(divisor_low) + 24'd1))
    else $error("async narrow rate wrong");
  chk_rate_async16: assert property (
    baud_tick && clean && !sync_sel && wide_sel && !hs_sel |->
    gap == 24'd16 * (24'(rule_div) + 24'd1))
    else $error("async wide rate wrong");
  chk_rate_sync: assert property (baud_tick && clean && sync_sel |->
    gap == 24'd4 * (24'(rule_div) + 24'd1))
    else $error("clocked rate wrong");
  chk_rate_fast: assert property (baud_tick && clean && !sync_sel &&
    hs_sel |-> gap == (wide_sel ? 24'd4 : 24'd16) * (24'(rule_div) + 24'd1))
    else $error("high speed rate wrong");
  chk_low_restart: assert property (wr_en && addr == ADDR_DIV_LOW |=>
    gen_count == 16'h0000 && pre_count == 6'h00)
    else $error("low write did not restart");
  // Tick is a single-cycle pulse; the prescaler limit is never zero
  chk_tick_single: assert property (baud_tick |=> !baud_tick)
    else $error("tick longer than one cycle");
  chk_wide_select: assert property (wr_en && addr == ADDR_BAUD_CTRL |=>
    wide_mode == $past(wr_data[BRC_WIDE_BIT]))
    else $error("wide select not applied");
  chk_mode_select: assert property (wr_en && addr == ADDR_TX_CTRL |=>
    sync_mode == $past(wr_data[TXC_SYNC_BIT]))
    else $error("mode select not applied");

  cov_async8: cover property (baud_tick && clean && !sync_sel && !wide_sel);
  cov_wide: cover property (baud_tick && clean && wide_sel && !sync_sel);
  cov_sync: cover property (baud_tick && clean && sync_sel);
  cov_restart: cover property (restart ##1 restart);
endmodule : ubg_baud_gen

// ---- rtl/ubg_pkg.sv ----
// Package of register map, field positions and divide constants for ubg
package ubg_pkg;
  // Register offsets on the plain register port
  localparam logic [2:0] ADDR_DIV_LOW    = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH   = 3'h1;
  localparam logic [2:0] ADDR_TX_CTRL    = 3'h2;
  localparam logic [2:0] ADDR_BAUD_CTRL  = 3'h3;
  localparam logic [2:0] ADDR_COUNT      = 3'h4;

  // Field positions in transmit_status_control
  localparam int TXC_SYNC_BIT   = 4;
  localparam int TXC_HSPEED_BIT = 2;
  // Field positions in baud_rate_control
  localparam int BRC_WIDE_BIT   = 3;

  // Values after reset
  localparam logic [7:0] DIV_LOW_RST    = 8'h00;
  localparam logic [7:0] DIV_HIGH_RST   = 8'h00;
  localparam logic [7:0] TX_CTRL_RST    = 8'h02;
  localparam logic [7:0] BAUD_CTRL_RST  = 8'h40;

  // Bits software may write; the others are read-only
  localparam logic [7:0] TX_CTRL_WMASK   = 8'hFD;
  localparam logic [7:0] BAUD_CTRL_WMASK = 8'h1B;

  // Prescaler limits (divide ratio minus one)
  localparam logic [5:0] PRE_DIV64 = 6'h3F;
  localparam logic [5:0] PRE_DIV16 = 6'h0F;
  localparam logic [5:0] PRE_DIV4  = 6'h03;

  // Width of the helper period counter
  localparam int GAP_WIDTH = 24;

  // Prescaler limit from the mode bits
  function automatic logic [5:0] ubg_pre_limit(input logic sync_sel,
                                               input logic wide_sel,
                                               input logic hs_sel);
    logic [5:0] lim;
    lim = PRE_DIV4;
    if (sync_sel) begin
      lim = PRE_DIV4;
    end else if (wide_sel) begin
      lim = hs_sel ? PRE_DIV4 : PRE_DIV16;
    end else begin
      lim = hs_sel ? PRE_DIV16 : PRE_DIV64;
    end
    return lim;
  endfunction : ubg_pre_limit
endpackage : ubg_pkg

// ---- rtl/ubg_counter.sv ----
// Wrapping up-counter with synchronous clear, used by the baud generator
`timescale 1ns/1ns
module ubg_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             clear,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] limit,
  output logic      [WIDTH-1:0] count,
  output logic                  wrap
);
  logic [WIDTH-1:0] next_count;  // Next counter value

  // Width must be usable
  if (WIDTH < 1) begin : g_bad_width
    $error("ubg_counter: WIDTH must be at least 1");
  end

  // Wrap pulse when the limit is reached on an enabled cycle
  assign wrap = enable && !clear && (count == limit);

  // Next value: clear wins, then wrap to zero, else count
  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (enable) begin
      next_count = (count == limit) ? '0 : count + 1'b1;
    end
  end

  // Counter register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule : ubg_counter

// ---- sim/tb_ubg_baud_gen.sv ----
// Self-checking testbench for the baud rate generator
`timescale 1ns/1ns
module tb_ubg_baud_gen;
  import ubg_pkg::*;

  logic       mclk;        // System clock, 25 MHz
  logic       nrst;        // Asynchronous reset, active low
  logic [2:0] addr;        // Register offset
  logic [7:0] wr_data;     // Write data
  logic       wr_en;       // Write strobe
  logic       rd_en;       // Read strobe
  logic [7:0] rd_data;     // Read data, one cycle after strobe
  logic       baud_tick;   // Bit rate pulse
  logic       sync_mode;   // Clocked mode level
  logic       wide_mode;   // Wide divisor level
  int         err_count;   // Mismatches seen
  int         comparisons; // Compares made
  int         gap_n;       // Measured cycle count
  int         k;           // Expected prescale
  int         n;           // Expected divisor

  ubg_baud_gen #(.DIV_WIDTH(16)) ubg_baud_gen_inst (
    .mclk      (mclk),
    .nrst      (nrst),
    .addr      (addr),
    .wr_data   (wr_data),
    .wr_en     (wr_en),
    .rd_en     (rd_en),
    .rd_data   (rd_data),
    .baud_tick (baud_tick),
    .sync_mode (sync_mode),
    .wide_mode (wide_mode)
  );

  // Clock generator, 40 ns period
  always #20 mclk = ~mclk;

  // Compare a seen value with the expected one
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle register write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge mclk);
    wr_en   <= 1'b0;
  endtask : wr

  // One-cycle register read; data stands one cycle, then zero
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    check(rd_data, exp);
    @(posedge mclk);
    #1;
    check(rd_data, 16'h0000);
  endtask : rd

  // Count cycles up to the next tick, bounded
  task automatic gap(output int cnt);
    cnt = 0;
    do begin
      @(posedge mclk);
      #1;
      cnt++;
    end while (baud_tick !== 1'b1 && cnt < 6000);
  endtask : gap

  // Expected prescale for a mode combination
  function automatic int exp_k(input logic s, input logic w, input logic h);
    if (s) return 4;
    if (w) return h ? 4 : 16;
    return h ? 16 : 64;
  endfunction : exp_k

  // Closing verdict
  task automatic give_verdict;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons,
             err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // Watchdog against a hang
  initial begin
    #(60000 * 40);
    err_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    mclk = 1'b0; nrst = 1'b0; addr = 3'h0; wr_data = 8'h00;
    wr_en = 1'b0; rd_en = 1'b0; err_count = 0; comparisons = 0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    // Reset values and unmapped offsets
    rd(ADDR_DIV_LOW, 8'h00);
    rd(ADDR_DIV_HIGH, 8'h00);
    rd(ADDR_TX_CTRL, 8'h02);
    rd(ADDR_BAUD_CTRL, 8'h40);
    rd(3'h7, 8'h00);
    check(sync_mode, 1'b0);
    check(wide_mode, 1'b0);
    $display("Test reset values done");
    // Access kinds and read-only bits
    wr(ADDR_DIV_HIGH, 8'hA5);
    rd(ADDR_DIV_HIGH, 8'hA5);
    wr(ADDR_TX_CTRL, 8'h00);
    rd(ADDR_TX_CTRL, 8'h02);
    wr(ADDR_BAUD_CTRL, 8'hFF);
    rd(ADDR_BAUD_CTRL, 8'h5B);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'h00);
    $display("Test register access done");
    // Every mode combination: restart gap and steady period
    wr(ADDR_DIV_HIGH, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_TX_CTRL, {3'h0, i[2], 1'b0, i[0], 2'h0});
      wr(ADDR_BAUD_CTRL, {4'h0, i[1], 3'h0});
      wr(ADDR_DIV_LOW, 8'h02);
      k = exp_k(i[2], i[1], i[0]);
      n = i[1] ? 258 : 2;
      gap(gap_n);
      check(16'(gap_n), 16'(k * (n + 1)));
      gap(gap_n);
      check(16'(gap_n), 16'(k * (n + 1)));
      check(sync_mode, i[2]);
      check(wide_mode, i[1]);
    end
    $display("Test divide ratios done");
    // High byte write in mid-count restarts the counter
    repeat (100) @(posedge mclk);
    wr(ADDR_DIV_HIGH, 8'h00);
    gap(gap_n);
    check(16'(gap_n), 16'h000C);
    // Narrow mode ignores the high byte
    wr(ADDR_BAUD_CTRL, 8'h00);
    wr(ADDR_DIV_HIGH, 8'hFF);
    gap(gap_n);
    check(16'(gap_n), 16'h000C);
    gap(gap_n);
    check(16'(gap_n), 16'h000C);
    $display("Test restart and narrow mode done");
    // Counter reads one the cycle after a restart has cleared it
    wr(ADDR_DIV_LOW, 8'h02);
    rd(ADDR_COUNT, 8'h01);
    // Mid-run reset returns the high byte and mode to reset values
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    rd(ADDR_DIV_HIGH, 8'h00);
    check(sync_mode, 1'b0);
    $display("Test count read and mid-run reset done");
    give_verdict();
  end
endmodule : tb_ubg_baud_gen
